// file: core/nco_preset_consts.vh
// Summary of operation
// - Source bit 0: active preset index comes from the three select pins.
// - Source bit 1: active preset index comes from the software index register.
// - Eight presets, 0 to 7, each with its own frequency word and phase offset.
// - Fine delay in use comes from the active preset's delay entry.
// - Index register is bits 2:0, honoured only while source bit is 1.
// - Source bit is bit 0, bits 7:1 reserved, reset zero selects pins.
// - Frequency word is 32 bits wide and may only approximate a frequency.
// - Rational step divisor is 16 bits over two bytes, reset zero.
// - One shared divisor serves all presets.
// - Output frequency is word times two to minus 32 times sample rate.
// - Active 16-bit phase offset sits in upper bits, added to accumulator.
`ifndef NCO_PRESET_CONSTS_VH
`define NCO_PRESET_CONSTS_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define ADDR_W            12
`define IDX_SRC_MODE      10'h20C
`define IDX_PRESET_INDEX  10'h20D
`define IDX_STEP_DIV      10'h20E
`define ADDR_STATUS       12'h880
`define ADDR_FREQ_BASE    12'h900
`define ADDR_PHASE_BASE   12'h920
`define ADDR_DELAY_BASE   12'h940

// ----------------------------------------
// Fields
// ----------------------------------------
`define SRC_MODE_BIT      0
`define INDEX_W           3
`define FREQ_W            32
`define PHASE_W           16
`define DELAY_W           8
`define STEP_DIV_W        16
`define PRESET_COUNT      8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SRC_MODE      1'h0
`define RST_INDEX         3'h0
`define RST_STEP_DIV      16'h0000
`define RST_FREQ          32'hC0000000
`define RST_PHASE         16'h0000
`define RST_DELAY         8'hFF

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// file: core/preset_store.v
`timescale 1ns/1ns
module preset_store #(
  parameter W     = 32,
  parameter DEPTH = 8,
  parameter IW    = 3,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          nrst_i,
  // Write port
  input  wire          wr_en_i,
  input  wire [IW-1:0] wr_addr_i,
  input  wire [W-1:0]  wr_mask_i,
  input  wire [W-1:0]  wr_data_i,
  // Software read port
  input  wire [IW-1:0] sw_addr_i,
  output reg  [W-1:0]  sw_data_o,
  // Active preset read port
  input  wire [IW-1:0] act_addr_i,
  output reg  [W-1:0]  act_data_o
);

  reg [W-1:0] mem_ff [0:DEPTH-1];
  integer     i;

  // ----------------------------------------
  // Storage and registered reads
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_ff[i] <= RST;
      sw_data_o  <= RST;
      act_data_o <= RST;
    end
    else
    begin
      if (wr_en_i)
        mem_ff[wr_addr_i] <= (mem_ff[wr_addr_i] & ~wr_mask_i) | (wr_data_i & wr_mask_i);
      sw_data_o  <= mem_ff[sw_addr_i];
      act_data_o <= mem_ff[act_addr_i];
    end
  end

endmodule // preset_store

// file: core/nco_preset_select_config.v
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`include "nco_preset_consts.vh"
module nco_preset_select_config (
  // Clock and reset
  input  wire                     clk_i,
  input  wire                     nrst_i,
  // AXI4-Lite write address
  input  wire                     s_axi_awvalid_i,
  output wire                     s_axi_awready_o,
  input  wire [`ADDR_W-1:0]       s_axi_awaddr_i,
  input  wire [2:0]               s_axi_awprot_i,
  // AXI4-Lite write data
  input  wire                     s_axi_wvalid_i,
  output wire                     s_axi_wready_o,
  input  wire [31:0]              s_axi_wdata_i,
  input  wire [3:0]               s_axi_wstrb_i,
  // AXI4-Lite write response
  output wire                     s_axi_bvalid_o,
  input  wire                     s_axi_bready_i,
  output wire [1:0]               s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire                     s_axi_arvalid_i,
  output wire                     s_axi_arready_o,
  input  wire [`ADDR_W-1:0]       s_axi_araddr_i,
  input  wire [2:0]               s_axi_arprot_i,
  // AXI4-Lite read data
  output wire                     s_axi_rvalid_o,
  input  wire                     s_axi_rready_i,
  output wire [31:0]              s_axi_rdata_o,
  output wire [1:0]               s_axi_rresp_o,
  // External preset select pins
  input  wire [`INDEX_W-1:0]      preset_select_pins_i,
  // Active preset configuration
  output wire [`INDEX_W-1:0]      active_preset_o,
  output wire [`FREQ_W-1:0]       oscillator_frequency_word_o,
  output wire [`PHASE_W-1:0]      oscillator_phase_offset_o,
  output wire [`DELAY_W-1:0]      downconverter_fine_delay_o,
  output wire [`STEP_DIV_W-1:0]   rational_step_divisor_o,
  output wire [`FREQ_W-1:0]       nco_phase_o
);

  // ----------------------------------------
  // Address decode codes
  // ----------------------------------------
  localparam [2:0] DEC_NONE  = 3'h0;
  localparam [2:0] DEC_MODE  = 3'h1;
  localparam [2:0] DEC_INDEX = 3'h2;
  localparam [2:0] DEC_DIV   = 3'h3;
  localparam [2:0] DEC_STAT  = 3'h4;
  localparam [2:0] DEC_FREQ  = 3'h5;
  localparam [2:0] DEC_PHASE = 3'h6;
  localparam [2:0] DEC_DELAY = 3'h7;

  localparam [`ADDR_W-1:0] A_MODE  = {`IDX_SRC_MODE, 2'h0};
  localparam [`ADDR_W-1:0] A_INDEX = {`IDX_PRESET_INDEX, 2'h0};
  localparam [`ADDR_W-1:0] A_DIV   = {`IDX_STEP_DIV, 2'h0};
  localparam [`ADDR_W-1:0] A_FREQ  = `ADDR_FREQ_BASE;
  localparam [`ADDR_W-1:0] A_PHASE = `ADDR_PHASE_BASE;
  localparam [`ADDR_W-1:0] A_DELAY = `ADDR_DELAY_BASE;

  function [2:0] decode;
    input [`ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'h0)
        decode = DEC_NONE;
      else if (a == A_MODE)
        decode = DEC_MODE;
      else if (a == A_INDEX)
        decode = DEC_INDEX;
      else if (a == A_DIV)
        decode = DEC_DIV;
      else if (a == `ADDR_STATUS)
        decode = DEC_STAT;
      else if (a[`ADDR_W-1:5] == A_FREQ[`ADDR_W-1:5])
        decode = DEC_FREQ;
      else if (a[`ADDR_W-1:5] == A_PHASE[`ADDR_W-1:5])
        decode = DEC_PHASE;
      else if (a[`ADDR_W-1:5] == A_DELAY[`ADDR_W-1:5])
        decode = DEC_DELAY;
      else
        decode = DEC_NONE;
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg                      aw_got_ff;
  reg                      w_got_ff;
  reg  [`ADDR_W-1:0]       awaddr_ff;
  reg  [31:0]              wdata_ff;
  reg  [3:0]               wstrb_ff;
  reg                      bvalid_ff;
  reg  [1:0]               bresp_ff;
  reg                      rd_busy_ff;
  reg                      rd_stage_ff;
  reg  [`ADDR_W-1:0]       araddr_ff;
  reg                      rvalid_ff;
  reg  [31:0]              rdata_ff;
  reg  [1:0]               rresp_ff;
  reg                      src_mode_ff;
  reg  [`INDEX_W-1:0]      preset_index_ff;
  reg  [`STEP_DIV_W-1:0]   step_div_ff;
  reg  [`INDEX_W-1:0]      pin_meta_ff;
  reg  [`INDEX_W-1:0]      pin_sync_ff;
  reg  [`INDEX_W-1:0]      active_ff;
  reg  [`FREQ_W-1:0]       acc_ff;
  reg  [`FREQ_W-1:0]       nco_phase_ff;
  reg  [31:0]              nxt_rdata;
  reg  [1:0]               nxt_rresp;
  wire                     aw_hs;
  wire                     w_hs;
  wire                     ar_hs;
  wire                     do_wr;
  wire [2:0]               wr_dec;
  wire [2:0]               rd_dec;
  wire [31:0]              byte_mask;
  wire [`INDEX_W-1:0]      active_idx;
  wire [`FREQ_W-1:0]       freq_sw;
  wire [`PHASE_W-1:0]      phase_sw;
  wire [`DELAY_W-1:0]      delay_sw;
  wire [`FREQ_W-1:0]       freq_act;
  wire [`PHASE_W-1:0]      phase_act;
  wire [`DELAY_W-1:0]      delay_act;

  // ----------------------------------------
  // Write channel handshakes
  // ----------------------------------------
  assign s_axi_awready_o = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready_o  = !w_got_ff && !bvalid_ff;
  assign aw_hs           = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs            = s_axi_wvalid_i && s_axi_wready_o;
  assign do_wr           = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_dec          = decode(awaddr_ff);
  assign byte_mask       = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                            {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= {`ADDR_W{1'b0}};
      wdata_ff  <= 32'h00000000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (w_hs)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (do_wr)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wr_dec == DEC_NONE || wr_dec == DEC_STAT) ? `RESP_SLVERR : `RESP_OKAY;
      end
      else if (bvalid_ff && s_axi_bready_i)
        bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      src_mode_ff     <= `RST_SRC_MODE;
      preset_index_ff <= `RST_INDEX;
      step_div_ff     <= `RST_STEP_DIV;
    end
    else if (do_wr)
    begin
      if (wr_dec == DEC_MODE && wstrb_ff[0])
        src_mode_ff <= wdata_ff[`SRC_MODE_BIT];
      if (wr_dec == DEC_INDEX && wstrb_ff[0])
        preset_index_ff <= wdata_ff[`INDEX_W-1:0];
      if (wr_dec == DEC_DIV)
        step_div_ff <= (step_div_ff & ~byte_mask[15:0])
                       | (wdata_ff[15:0] & byte_mask[15:0]);
    end
  end

  // ----------------------------------------
  // Preset select pin synchroniser
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pin_meta_ff <= `RST_INDEX;
      pin_sync_ff <= `RST_INDEX;
    end
    else
    begin
      pin_meta_ff <= preset_select_pins_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ----------------------------------------
  // Active preset selection
  // ----------------------------------------
  assign active_idx = src_mode_ff ? preset_index_ff : pin_sync_ff;

  // ----------------------------------------
  // Per-preset storage
  // ----------------------------------------
  preset_store #(
    .W     (`FREQ_W),
    .DEPTH (`PRESET_COUNT),
    .IW    (`INDEX_W),
    .RST   (`RST_FREQ)
  ) u_freq (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .wr_en_i    (do_wr && wr_dec == DEC_FREQ),
    .wr_addr_i  (awaddr_ff[4:2]),
    .wr_mask_i  (byte_mask),
    .wr_data_i  (wdata_ff),
    .sw_addr_i  (s_axi_araddr_i[4:2]),
    .sw_data_o  (freq_sw),
    .act_addr_i (active_idx),
    .act_data_o (freq_act)
  );

  preset_store #(
    .W     (`PHASE_W),
    .DEPTH (`PRESET_COUNT),
    .IW    (`INDEX_W),
    .RST   (`RST_PHASE)
  ) u_phase (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .wr_en_i    (do_wr && wr_dec == DEC_PHASE),
    .wr_addr_i  (awaddr_ff[4:2]),
    .wr_mask_i  (byte_mask[15:0]),
    .wr_data_i  (wdata_ff[15:0]),
    .sw_addr_i  (s_axi_araddr_i[4:2]),
    .sw_data_o  (phase_sw),
    .act_addr_i (active_idx),
    .act_data_o (phase_act)
  );

  preset_store #(
    .W     (`DELAY_W),
    .DEPTH (`PRESET_COUNT),
    .IW    (`INDEX_W),
    .RST   (`RST_DELAY)
  ) u_delay (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .wr_en_i    (do_wr && wr_dec == DEC_DELAY),
    .wr_addr_i  (awaddr_ff[4:2]),
    .wr_mask_i  (byte_mask[7:0]),
    .wr_data_i  (wdata_ff[7:0]),
    .sw_addr_i  (s_axi_araddr_i[4:2]),
    .sw_data_o  (delay_sw),
    .act_addr_i (active_idx),
    .act_data_o (delay_act)
  );

  // ----------------------------------------
  // Phase accumulator
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      active_ff    <= `RST_INDEX;
      acc_ff       <= {`FREQ_W{1'b0}};
      nco_phase_ff <= {`FREQ_W{1'b0}};
    end
    else
    begin
      active_ff    <= active_idx;
      acc_ff       <= acc_ff + freq_act;
      nco_phase_ff <= acc_ff + {phase_act, 16'h0000};
    end
  end

  assign active_preset_o             = active_ff;
  assign oscillator_frequency_word_o = freq_act;
  assign oscillator_phase_offset_o   = phase_act;
  assign downconverter_fine_delay_o  = delay_act;
  assign rational_step_divisor_o     = step_div_ff;
  assign nco_phase_o                 = nco_phase_ff;

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign s_axi_arready_o = !rd_busy_ff;
  assign ar_hs           = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_dec          = decode(araddr_ff);
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rdata_o   = rdata_ff;
  assign s_axi_rresp_o   = rresp_ff;

  always @*
  begin
    nxt_rdata = 32'h00000000;
    nxt_rresp = `RESP_OKAY;
    case (rd_dec)
      DEC_MODE:  nxt_rdata = {31'h00000000, src_mode_ff};
      DEC_INDEX: nxt_rdata = {29'h00000000, preset_index_ff};
      DEC_DIV:   nxt_rdata = {16'h0000, step_div_ff};
      DEC_STAT:  nxt_rdata = {25'h0000000, pin_sync_ff, src_mode_ff, active_ff};
      DEC_FREQ:  nxt_rdata = freq_sw;
      DEC_PHASE: nxt_rdata = {16'h0000, phase_sw};
      DEC_DELAY: nxt_rdata = {24'h000000, delay_sw};
      default:   nxt_rresp = `RESP_SLVERR;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      rd_busy_ff  <= 1'b0;
      rd_stage_ff <= 1'b0;
      araddr_ff   <= {`ADDR_W{1'b0}};
      rvalid_ff   <= 1'b0;
      rdata_ff    <= 32'h00000000;
      rresp_ff    <= `RESP_OKAY;
    end
    else
    begin
      if (ar_hs)
      begin
        rd_busy_ff  <= 1'b1;
        rd_stage_ff <= 1'b1;
        araddr_ff   <= s_axi_araddr_i;
      end
      if (rd_stage_ff)
      begin
        rd_stage_ff <= 1'b0;
        rvalid_ff   <= 1'b1;
        rdata_ff    <= nxt_rdata;
        rresp_ff    <= nxt_rresp;
      end
      else if (rvalid_ff && s_axi_rready_i)
      begin
        rvalid_ff  <= 1'b0;
        rd_busy_ff <= 1'b0;
      end
    end
  end

endmodule // nco_preset_select_config

// file: dv/nco_preset_select_config_sva.sv
`timescale 1ns/1ns
module nco_preset_select_config_sva (
  // Clock and reset
  input logic        clk_i,
  input logic        nrst_i,
  // Register bus
  input logic        s_axi_awvalid_i,
  input logic        s_axi_awready_o,
  input logic        s_axi_wvalid_i,
  input logic        s_axi_wready_o,
  input logic        s_axi_bvalid_o,
  input logic        s_axi_bready_i,
  input logic [1:0]  s_axi_bresp_o,
  input logic        s_axi_arvalid_i,
  input logic        s_axi_arready_o,
  input logic        s_axi_rvalid_o,
  input logic        s_axi_rready_i,
  input logic [31:0] s_axi_rdata_o,
  // Active preset
  input logic [2:0]  active_preset_o,
  input logic [31:0] oscillator_frequency_word_o,
  input logic [15:0] oscillator_phase_offset_o,
  input logic [15:0] rational_step_divisor_o,
  input logic [31:0] nco_phase_o
);
  logic [1:0] steady_ff;

  // Counts cycles with word and offset unchanged
  always @(posedge clk_i)
  begin
    if (!nrst_i || !$stable(oscillator_frequency_word_o) || !$stable(oscillator_phase_offset_o))
      steady_ff <= 2'h0;
    else if (steady_ff != 2'h3)
      steady_ff <= steady_ff + 2'h1;
  end

  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_WR_RESP: assert property (s_wr_take |-> ##2 s_axi_bvalid_o)
    else $error("write response missing");
  AST_RD_RESP: assert property (s_rd_take |-> ##[2:3] s_axi_rvalid_o)
    else $error("read response missing");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  AST_AR_BUSY: assert property (s_rd_take |=> !s_axi_arready_o [*2])
    else $error("read taken while busy");
  AST_B_BLOCK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");
  AST_PHASE_STEP: assert property (steady_ff == 2'h3 |->
    (nco_phase_o - $past(nco_phase_o)) == $past(oscillator_frequency_word_o, 2))
    else $error("phase step differs from frequency word");
  AST_RST_VAL: assert property ($rose(nrst_i) |->
    rational_step_divisor_o == 16'h0000 &&
    active_preset_o == 3'h0 && oscillator_frequency_word_o == 32'hC0000000)
    else $error("reset values wrong");
  AST_DIV_WRITE: assert property ($changed(rational_step_divisor_o) |->
    $rose(s_axi_bvalid_o))
    else $error("divisor moved without a write");
endmodule // nco_preset_select_config_sva

bind nco_preset_select_config nco_preset_select_config_sva u_sva (.*);

// file: dv/preset_pin_driver.sv
`timescale 1ns/1ns
module preset_pin_driver (
  // Requested preset
  input  logic [2:0] preset_req_i,
  // Board pins, moved off the clock grid
  output wire  [2:0] preset_select_pins_o
);
  assign #3 preset_select_pins_o = preset_req_i;
endmodule // preset_pin_driver

// file: dv/nco_preset_select_config_bench.sv
`timescale 1ns/1ns
`include "nco_preset_consts.vh"
module nco_preset_select_config_bench;
  localparam logic [11:0] A_MODE = `IDX_SRC_MODE * 4;
  localparam logic [11:0] A_SEL  = `IDX_PRESET_INDEX * 4;
  localparam logic [11:0] A_DIV  = `IDX_STEP_DIV * 4;
  localparam int          DIV_V  = 3072000 / 10 / 128;
  logic        clk_i, nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_rready_i;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [2:0]  s_axi_awprot_i, s_axi_arprot_i, pin_req;
  logic [31:0] s_axi_wdata_i;
  logic [3:0]  s_axi_wstrb_i;
  wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  wire  [31:0] s_axi_rdata_o, oscillator_frequency_word_o, nco_phase_o;
  wire  [2:0]  preset_select_pins_i, active_preset_o;
  wire  [15:0] oscillator_phase_offset_o, rational_step_divisor_o;
  wire  [7:0]  downconverter_fine_delay_o;
  int          err_count, compares, i;

  nco_preset_select_config DUT (.*);
  preset_pin_driver u_pins (.preset_req_i(pin_req), .preset_select_pins_o(preset_select_pins_i));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] fw(input int x);
    fw = 32'h80000001 + x * 32'h11111111;
  endfunction
  function automatic logic [31:0] pw(input int x);
    pw = 32'hA000 + x;
  endfunction

  task automatic test_done;
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk_i);
    s_axi_awvalid_i <= 1'b1;
    s_axi_awaddr_i <= a;
    s_axi_wvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_bready_i <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge clk_i);
      ta = s_axi_awvalid_i && s_axi_awready_o;
      tw = s_axi_wvalid_i && s_axi_wready_o;
      tb = s_axi_bready_i && s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge clk_i);
      if (ta) s_axi_awvalid_i <= 1'b0;
      if (tw) s_axi_wvalid_i <= 1'b0;
      if (tb)
      begin
        s_axi_bready_i <= 1'b0;
        return;
      end
    end
    err_count++;
    test_done();
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk_i);
    s_axi_arvalid_i <= 1'b1;
    s_axi_araddr_i <= a;
    s_axi_rready_i <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge clk_i);
      ta = s_axi_arvalid_i && s_axi_arready_o;
      tr = s_axi_rready_i && s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge clk_i);
      if (ta) s_axi_arvalid_i <= 1'b0;
      if (tr)
      begin
        s_axi_rready_i <= 1'b0;
        return;
      end
    end
    err_count++;
    test_done();
  endtask

  task automatic put(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", e, r);
  endtask

  task automatic get(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("rresp", er, r);
    chk("rdata", e, d);
  endtask

  task automatic act(input int x);
    chk("active", x, active_preset_o);
    chk("freq", fw(x), oscillator_frequency_word_o);
    chk("phase", pw(x), oscillator_phase_offset_o);
    chk("delay", 32'h10 + x, downconverter_fine_delay_o);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    get(A_MODE, 32'h0, `RESP_OKAY);
    get(A_SEL, 32'h0, `RESP_OKAY);
    get(A_DIV, 32'h0, `RESP_OKAY);
    chk("freq", 32'hC0000000, oscillator_frequency_word_o);
    chk("delay", 32'hFF, downconverter_fine_delay_o);
  endtask

  task automatic t_sw_select;
    for (i = 0; i < `PRESET_COUNT; i++)
    begin
      put(12'(`ADDR_FREQ_BASE + 4 * i), fw(i), `RESP_OKAY);
      put(12'(`ADDR_PHASE_BASE + 4 * i), pw(i), `RESP_OKAY);
      put(12'(`ADDR_DELAY_BASE + 4 * i), 32'h10 + i, `RESP_OKAY);
    end
    put(A_MODE, 32'h1, `RESP_OKAY);
    for (i = `PRESET_COUNT - 1; i >= 0; i--)
    begin
      put(A_SEL, 32'hFFFFFFF8 | i, `RESP_OKAY);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      act(i);
      get(A_SEL, i, `RESP_OKAY);
    end
  endtask

  task automatic t_pin_select;
    put(A_MODE, 32'hFE, `RESP_OKAY);
    get(A_MODE, 32'h0, `RESP_OKAY);
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    act(0);
    for (i = 1; i < `PRESET_COUNT; i++)
    begin
      @(posedge clk_i);
      pin_req <= 3'(i);
      @(posedge clk_i);
      @(negedge clk_i);
      chk("active", i - 1, active_preset_o);
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      act(i);
    end
  endtask

  task automatic t_divisor;
    logic [31:0] p0;
    put(A_DIV, 32'hABCD0000 | DIV_V, `RESP_OKAY);
    get(A_DIV, DIV_V, `RESP_OKAY);
    @(posedge clk_i);
    pin_req <= 3'h3;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    act(3);
    p0 = nco_phase_o;
    @(negedge clk_i);
    chk("phase_step", fw(3), nco_phase_o - p0);
    chk("divisor", DIV_V, rational_step_divisor_o);
    put(A_DIV, 32'h2000, `RESP_OKAY);
    chk("divisor", 32'h2000, rational_step_divisor_o);
  endtask

  task automatic t_errors;
    get(12'h7F0, 32'h0, `RESP_SLVERR);
    get(12'h831, 32'h0, `RESP_SLVERR);
    put(`ADDR_STATUS, 32'hFF, `RESP_SLVERR);
    get(`ADDR_STATUS, 32'h33, `RESP_OKAY);
  endtask

  initial
  begin
    err_count = 0;
    compares = 0;
    nrst_i = 1'b0;
    pin_req = 3'h0;
    s_axi_awvalid_i = 1'b0;
    s_axi_wvalid_i = 1'b0;
    s_axi_bready_i = 1'b0;
    s_axi_arvalid_i = 1'b0;
    s_axi_rready_i = 1'b0;
    s_axi_awaddr_i = 12'h000;
    s_axi_araddr_i = 12'h000;
    s_axi_awprot_i = 3'h0;
    s_axi_arprot_i = 3'h0;
    s_axi_wdata_i = 32'h00000000;
    s_axi_wstrb_i = 4'hF;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_sw_select();
    t_pin_select();
    t_divisor();
    t_errors();
    test_done();
  end
endmodule // nco_preset_select_config_bench
